// file: logic/gsmr_menu_relay.sv
// Setup menu controller, setpoint relay and register slave for the gauge
//
// Summary of operation
// - Up held 5 s restores every factory default, then normal display.
// - While up is held toward reset, readout shows defaults-pending.
// - Up released before 5 s returns to normal display, settings kept.
// - Select held 3 s from normal display enters setup at turn-on value.
// - Relay energises when pressure falls below turn-on setpoint (100).
// - Relay de-energises when pressure rises above turn-off setpoint (200).
// - At setpoint steps up/down adjust; select saves and advances.
// - After turn-off step, zero adjust shows 000; zero default is 000.
// - In zero adjust, down stores present reading as zero and exits.
// - In zero adjust, select advances to span, zero unchanged.
// - Span step shows span (default 760 Torr); up/down change it.
// - Brief select at span step exits without saving span.
// - Select held 3 s at span step stores new span and exits.
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module gsmr_menu_relay #(
  parameter int unsigned TICK_CYC = gsmr_pkg::TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Front-panel switch pins
  input wire logic key_sel_i,
  input wire logic key_up_i,
  input wire logic key_dn_i,
  // Measured pressure in mTorr from the measurement logic
  input wire logic [gsmr_pkg::VAL_W-1:0] pressure_i,
  // Readout and relay
  output gsmr_pkg::gsmr_disp_t disp_code_o,
  output logic [gsmr_pkg::VAL_W-1:0] disp_val_o,
  output logic defaults_pending_indicator_o,
  output logic relay_o,
  // AXI4-Lite slave
  input wire logic [gsmr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gsmr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import gsmr_pkg::*;

  gsmr_key_if keys ();
  logic tick;

  // Key conditioning and time base
  gsmr_key_sync u_keys (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .key_i({key_dn_i, key_up_i, key_sel_i}),
    .keys(keys)
  );

  gsmr_tick_gen #(.TICK_CYC(TICK_CYC)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  gsmr_state_t state_ff;
  gsmr_state_t nxt_state;
  logic [VAL_W-1:0] sp_on_ff;
  logic [VAL_W-1:0] sp_off_ff;
  logic [VAL_W-1:0] zero_ff;
  logic [VAL_W-1:0] span_ff;
  logic [VAL_W-1:0] edit_ff;
  logic [VAL_W-1:0] nxt_sp_on;
  logic [VAL_W-1:0] nxt_sp_off;
  logic [VAL_W-1:0] nxt_zero;
  logic [VAL_W-1:0] nxt_span;
  logic [VAL_W-1:0] nxt_edit;
  logic arm_ff;
  logic nxt_arm;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic relay_ff;
  logic nxt_relay;
  logic inhibit_ff;
  gsmr_disp_t disp_code_ff;
  gsmr_disp_t nxt_disp_code;
  logic [VAL_W-1:0] disp_val_ff;
  logic [VAL_W-1:0] nxt_disp_val;
  logic def_ind_ff;

  // Named key events
  wire logic sel_lvl = keys.level[KEY_SEL];
  wire logic up_lvl = keys.level[KEY_UP];
  wire logic sel_rise = keys.rise[KEY_SEL];
  wire logic up_rise = keys.rise[KEY_UP];
  wire logic dn_rise = keys.rise[KEY_DN];
  wire logic setup_done = (cnt_ff >= SETUP_HOLD_TICKS);
  wire logic def_done = (cnt_ff >= DEF_HOLD_TICKS);
  wire logic [VAL_W-1:0] edit_up = edit_ff + STEP;
  wire logic [VAL_W-1:0] edit_dn = edit_ff - STEP;
  wire logic [VAL_W-1:0] edit_adj = up_rise ? edit_up :
                                    dn_rise ? edit_dn : edit_ff;
  wire logic [VAL_W-1:0] press_net = (pressure_i > zero_ff) ?
                                     pressure_i - zero_ff : 16'h0000;

  // Menu sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_sp_on = sp_on_ff;
    nxt_sp_off = sp_off_ff;
    nxt_zero = zero_ff;
    nxt_span = span_ff;
    nxt_edit = edit_ff;
    nxt_arm = arm_ff;
    nxt_cnt = (arm_ff && tick && !(&cnt_ff)) ? cnt_ff + CNT_W'(1) : cnt_ff;
    unique case (state_ff)
      ST_NORM: begin
        nxt_arm = 1'h0;
        nxt_cnt = '0;
        if (sel_rise) begin
          nxt_state = ST_ENTER;
          nxt_arm = 1'h1;
        end else if (up_rise) begin
          nxt_state = ST_DEF;
          nxt_arm = 1'h1;
        end
      end
      ST_ENTER: begin
        if (!sel_lvl) begin
          nxt_state = ST_NORM;
        end else if (setup_done) begin
          nxt_state = ST_SP_ON;
          nxt_edit = sp_on_ff;
          nxt_arm = 1'h0;
        end
      end
      ST_DEF: begin
        if (!up_lvl) begin
          nxt_state = ST_NORM;
        end else if (def_done) begin
          nxt_state = ST_NORM;
          nxt_sp_on = SP_ON_DEF;
          nxt_sp_off = SP_OFF_DEF;
          nxt_zero = ZERO_DEF;
          nxt_span = SPAN_DEF;
        end
      end
      ST_SP_ON: begin
        nxt_edit = edit_adj;
        if (sel_rise) begin
          nxt_sp_on = edit_ff;
          nxt_edit = sp_off_ff;
          nxt_state = ST_SP_OFF;
        end
      end
      ST_SP_OFF: begin
        nxt_edit = edit_adj;
        if (sel_rise) begin
          nxt_sp_off = edit_ff;
          nxt_state = ST_ZERO;
        end
      end
      ST_ZERO: begin
        if (dn_rise) begin
          nxt_zero = pressure_i;
          nxt_state = ST_NORM;
        end else if (sel_rise) begin
          nxt_edit = span_ff;
          nxt_state = ST_SPAN;
        end
      end
      ST_SPAN: begin
        if (!arm_ff) begin
          nxt_edit = edit_adj;
          nxt_cnt = '0;
          nxt_arm = sel_rise;
        end else if (setup_done) begin
          nxt_span = edit_ff;
          nxt_state = ST_NORM;
        end else if (!sel_lvl) begin
          nxt_state = ST_NORM;
        end
      end
    endcase
  end

  // Readout selection for the next state
  always_comb begin
    nxt_disp_code = DISP_PRESSURE;
    nxt_disp_val = press_net;
    unique case (nxt_state)
      ST_NORM, ST_ENTER: begin
        nxt_disp_code = DISP_PRESSURE;
      end
      ST_DEF: begin
        nxt_disp_code = DISP_DEFAULTS_PENDING;
        nxt_disp_val = 16'h0000;
      end
      ST_ZERO: begin
        nxt_disp_code = DISP_ZERO;
        nxt_disp_val = 16'h0000;
      end
      ST_SP_ON, ST_SP_OFF, ST_SPAN: begin
        nxt_disp_code = DISP_VALUE;
        nxt_disp_val = nxt_edit;
      end
    endcase
  end

  // Setpoint relay with hysteresis and software inhibit
  always_comb begin
    nxt_relay = relay_ff;
    if (pressure_i < sp_on_ff) begin
      nxt_relay = 1'h1;
    end else if (pressure_i > sp_off_ff) begin
      nxt_relay = 1'h0;
    end
    if (inhibit_ff) begin
      nxt_relay = 1'h0;
    end
  end

  // Menu, settings and hold counter registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_NORM;
      sp_on_ff <= SP_ON_DEF;
      sp_off_ff <= SP_OFF_DEF;
      zero_ff <= ZERO_DEF;
      span_ff <= SPAN_DEF;
      edit_ff <= 16'h0000;
      arm_ff <= 1'h0;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      sp_on_ff <= nxt_sp_on;
      sp_off_ff <= nxt_sp_off;
      zero_ff <= nxt_zero;
      span_ff <= nxt_span;
      edit_ff <= nxt_edit;
      arm_ff <= nxt_arm;
      cnt_ff <= nxt_cnt;
    end
  end

  // Output registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      relay_ff <= 1'h0;
      disp_code_ff <= DISP_PRESSURE;
      disp_val_ff <= 16'h0000;
      def_ind_ff <= 1'h0;
    end else begin
      relay_ff <= nxt_relay;
      disp_code_ff <= nxt_disp_code;
      disp_val_ff <= nxt_disp_val;
      def_ind_ff <= (nxt_state == ST_DEF);
    end
  end

  assign relay_o = relay_ff;
  assign disp_code_o = disp_code_ff;
  assign disp_val_o = disp_val_ff;
  assign defaults_pending_indicator_o = def_ind_ff;

  // AXI4-Lite write channel state
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  wire logic aw_take = s_axi_awvalid & awready_ff;
  wire logic w_take = s_axi_wvalid & wready_ff;
  wire logic wr_do = ~awready_ff & ~wready_ff & ~bvalid_ff;
  wire logic wr_cfg = (awaddr_ff == OFS_CFG);
  wire logic wr_ro = (awaddr_ff == OFS_STATUS) ||
                     (awaddr_ff == OFS_SP_ON) ||
                     (awaddr_ff == OFS_SP_OFF) ||
                     (awaddr_ff == OFS_ZERO) ||
                     (awaddr_ff == OFS_SPAN);
  wire logic [1:0] wr_resp = wr_cfg ? RESP_OKAY :
                             wr_ro ? RESP_SLVERR : RESP_DECERR;

  // Address and data taken in either order, answer after both
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      awready_ff <= 1'h1;
      wready_ff <= 1'h1;
      bvalid_ff <= 1'h0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      inhibit_ff <= CFG_INHIBIT_RST;
    end else begin
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
        awready_ff <= 1'h0;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        wready_ff <= 1'h0;
      end
      if (wr_do) begin
        bvalid_ff <= 1'h1;
        bresp_ff <= wr_resp;
        if (wr_cfg && wstrb_ff[0]) begin
          inhibit_ff <= wdata_ff[CFG_INHIBIT_BIT];
        end
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'h0;
        awready_ff <= 1'h1;
        wready_ff <= 1'h1;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // AXI4-Lite read channel
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_mux;
  logic rd_hit;
  wire logic ar_take = s_axi_arvalid & arready_ff;
  wire logic [31:0] status_word = {16'h0000, 2'h0, disp_code_ff, 3'h0,
                                   relay_ff, 1'h0, state_ff};

  // Read data selection
  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'h1;
    unique case (s_axi_araddr)
      OFS_CFG: rd_mux = {31'h0, inhibit_ff};
      OFS_STATUS: rd_mux = status_word;
      OFS_SP_ON: rd_mux = {16'h0000, sp_on_ff};
      OFS_SP_OFF: rd_mux = {16'h0000, sp_off_ff};
      OFS_ZERO: rd_mux = {16'h0000, zero_ff};
      OFS_SPAN: rd_mux = {16'h0000, span_ff};
      default: rd_hit = 1'h0;
    endcase
  end

  // One read in flight, data held until taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arready_ff <= 1'h1;
      rvalid_ff <= 1'h0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0;
    end else begin
      if (ar_take) begin
        arready_ff <= 1'h0;
        rvalid_ff <= 1'h1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'h0;
        arready_ff <= 1'h1;
      end
    end
  end

  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
endmodule : gsmr_menu_relay

// file: logic/gsmr_pkg.sv
// Constants, layouts and types shared by the setup menu and relay block
package gsmr_pkg;
  // Timing: module clock and local time tick
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TICKS_PER_S = 1_000_000 / TICK_US;
  localparam int unsigned SETUP_HOLD_S = 3;
  localparam int unsigned DEF_HOLD_S = 5;
  localparam int unsigned CNT_W = 13;
  localparam logic [CNT_W-1:0] SETUP_HOLD_TICKS =
    CNT_W'(SETUP_HOLD_S * TICKS_PER_S);
  localparam logic [CNT_W-1:0] DEF_HOLD_TICKS =
    CNT_W'(DEF_HOLD_S * TICKS_PER_S);
  // Settings: setpoints and zero in mTorr, span in Torr
  localparam int unsigned VAL_W = 16;
  localparam logic [VAL_W-1:0] SP_ON_DEF = 16'h0064;
  localparam logic [VAL_W-1:0] SP_OFF_DEF = 16'h00C8;
  localparam logic [VAL_W-1:0] ZERO_DEF = 16'h0000;
  localparam logic [VAL_W-1:0] SPAN_DEF = 16'h02F8;
  localparam logic [VAL_W-1:0] STEP = 16'h0001;
  // Register map, byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SP_ON = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SP_OFF = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ZERO = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SPAN = 8'h14;
  localparam int unsigned CFG_INHIBIT_BIT = 0;
  localparam logic CFG_INHIBIT_RST = 1'h0;
  localparam int unsigned STATUS_RELAY_BIT = 8;
  localparam int unsigned STATUS_DISP_LSB = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Key pins
  localparam int unsigned NKEYS = 3;
  localparam int unsigned KEY_SEL = 0;
  localparam int unsigned KEY_UP = 1;
  localparam int unsigned KEY_DN = 2;
  // Menu states
  typedef enum logic [6:0] {
    ST_NORM = 7'h01,
    ST_ENTER = 7'h02,
    ST_DEF = 7'h04,
    ST_SP_ON = 7'h08,
    ST_SP_OFF = 7'h10,
    ST_ZERO = 7'h20,
    ST_SPAN = 7'h40
  } gsmr_state_t;
  // Readout content
  typedef enum logic [1:0] {
    DISP_PRESSURE = 2'h0,
    DISP_VALUE = 2'h1,
    DISP_ZERO = 2'h2,
    DISP_DEFAULTS_PENDING = 2'h3
  } gsmr_disp_t;
endpackage : gsmr_pkg

// file: logic/gsmr_key_if.sv
// Debounced key levels and edge pulses between key conditioner and menu
`timescale 1ns/1ps
interface gsmr_key_if;
  logic [gsmr_pkg::NKEYS-1:0] level;
  logic [gsmr_pkg::NKEYS-1:0] rise;
  logic [gsmr_pkg::NKEYS-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : gsmr_key_if

// file: logic/gsmr_key_sync.sv
// Three-stage key synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module gsmr_key_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [gsmr_pkg::NKEYS-1:0] key_i,
  gsmr_key_if.src keys
);
  import gsmr_pkg::*;

  logic [NKEYS-1:0] s1_ff;
  logic [NKEYS-1:0] s2_ff;
  logic [NKEYS-1:0] s3_ff;
  logic [NKEYS-1:0] lvl_ff;
  logic [NKEYS-1:0] rise_ff;
  logic [NKEYS-1:0] fall_ff;

  genvar k;
  generate
    for (k = 0; k < NKEYS; k++) begin : g_key
      // Level changes only when stages two and three agree
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_ff[k] <= 1'h0;
          s2_ff[k] <= 1'h0;
          s3_ff[k] <= 1'h0;
          lvl_ff[k] <= 1'h0;
          rise_ff[k] <= 1'h0;
          fall_ff[k] <= 1'h0;
        end else begin
          s1_ff[k] <= key_i[k];
          s2_ff[k] <= s1_ff[k];
          s3_ff[k] <= s2_ff[k];
          if (s2_ff[k] == s3_ff[k]) begin
            lvl_ff[k] <= s3_ff[k];
          end
          rise_ff[k] <= (s2_ff[k] == s3_ff[k]) & s3_ff[k] & ~lvl_ff[k];
          fall_ff[k] <= (s2_ff[k] == s3_ff[k]) & ~s3_ff[k] & lvl_ff[k];
        end
      end
    end
  endgenerate

  // Pulses line up with the cycle the level first shows its new value
  assign keys.level = lvl_ff;
  assign keys.rise = rise_ff;
  assign keys.fall = fall_ff;
endmodule : gsmr_key_sync

// file: logic/gsmr_tick_gen.sv
// Free-running divider giving the one-cycle time tick for hold timing
`timescale 1ns/1ps
module gsmr_tick_gen #(
  parameter int unsigned TICK_CYC = gsmr_pkg::TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  logic [31:0] cnt_ff;
  logic tick_ff;
  wire logic wrap = (cnt_ff == 32'(TICK_CYC - 1));

  // Count clock cycles, pulse once per tick period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 32'h0;
      tick_ff <= 1'h0;
    end else begin
      cnt_ff <= wrap ? 32'h0 : cnt_ff + 32'h1;
      tick_ff <= wrap;
    end
  end

  assign tick_o = tick_ff;
endmodule : gsmr_tick_gen

// file: sim/gsmr_operator.sv
// Operator model pressing the three-position front-panel switch
`timescale 1ns/1ps
module gsmr_operator (
  input wire logic clk_i,
  output logic [2:0] key_o
);
  // Switch rests released at time zero
  initial begin
    key_o = 3'h0;
  end
  // Hold one key for n cycles, then leave it released for a settle gap
  task press(input int k, input int n);
    key_o[k] <= 1'b1;
    repeat (n) @(posedge clk_i);
    key_o[k] <= 1'b0;
    repeat (30) @(posedge clk_i);
  endtask : press
endmodule : gsmr_operator

// file: sim/gsmr_checker.sv
// Port-level assertions for the setup menu and relay block
`timescale 1ns/1ps
module gsmr_checker
  import gsmr_pkg::*;
#(
  parameter int unsigned TICK_CYC = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic key_sel_i,
  input wire logic key_up_i,
  input gsmr_pkg::gsmr_disp_t disp_code_o,
  input wire logic [gsmr_pkg::VAL_W-1:0] disp_val_o,
  input wire logic defaults_pending_indicator_o,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int MIN_SEL = (SETUP_HOLD_S * TICKS_PER_S - 1) * TICK_CYC;
  logic [31:0] sel_cnt_ff;
  logic [31:0] nxt_sel_cnt;
  // Saturating count of cycles with select held
  assign nxt_sel_cnt = (&sel_cnt_ff) ? sel_cnt_ff : sel_cnt_ff + 32'h1;
  always_ff @(posedge clk_i) begin
    if (rst_i || !key_sel_i) begin
      sel_cnt_ff <= 32'h0;
    end else begin
      sel_cnt_ff <= nxt_sel_cnt;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Handshake steps of the register bus
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response missing");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_read_answer: assert property (s_rd_taken
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_pend_shown: assert property (defaults_pending_indicator_o
    |-> disp_code_o == DISP_DEFAULTS_PENDING) else $error("pending hidden");
  a_pend_cause: assert property ($rose(defaults_pending_indicator_o)
    |-> key_up_i) else $error("pending without up key");
  a_pend_release: assert property ($fell(key_up_i) &&
    defaults_pending_indicator_o |-> ##[1:12] !defaults_pending_indicator_o)
    else $error("pending stuck after release");
  a_zero_blank: assert property (disp_code_o == DISP_ZERO
    |-> disp_val_o == 16'h0000) else $error("zero step not blank");
  a_setup_hold: assert property (disp_code_o == DISP_VALUE &&
    $past(disp_code_o) == DISP_PRESSURE |-> sel_cnt_ff >= MIN_SEL)
    else $error("setup entered too soon");
endmodule : gsmr_checker
bind gsmr_menu_relay gsmr_checker #(.TICK_CYC(TICK_CYC)) chk_u (
  .clk_i, .rst_i, .key_sel_i, .key_up_i, .disp_code_o, .disp_val_o,
  .defaults_pending_indicator_o, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

// file: sim/tb_top.sv
// Self-checking bench for the setup menu and relay block
`timescale 1ns/1ps
module tb_top;
  import gsmr_pkg::*;
  localparam int unsigned TC = 2;
  localparam int H3 = 3000 * TC + 2 * TC + 40;
  localparam int H5 = 5000 * TC + 2 * TC + 40;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] pressure_i = 16'h0096;
  gsmr_disp_t disp_code_o;
  logic [15:0] disp_val_o;
  logic defaults_pending_indicator_o, relay_o;
  logic [2:0] keys;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] pr [6] = '{16'h0096, 16'h0063, 16'h0096, 16'h00C9,
                          16'h0096, 16'h0063};
  logic rl [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  int n_fail = 0;
  int n_checks = 0;
  gsmr_operator op_u (.clk_i, .key_o(keys));
  gsmr_menu_relay #(.TICK_CYC(TC)) dut_u (
    .clk_i, .rst_i, .key_sel_i(keys[KEY_SEL]), .key_up_i(keys[KEY_UP]),
    .key_dn_i(keys[KEY_DN]), .pressure_i, .disp_code_o, .disp_val_o,
    .defaults_pending_indicator_o, .relay_o, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // Print counts and verdict, then stop
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tmo(input int n);
    if (n > 500) begin
      n_fail++;
      complete_run();
    end
  endtask : tmo
  // One register write; response code lands in rsp
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      tmo(n);
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Let an edge pass so a following call never re-drives in this step
    @(posedge clk_i);
  endtask : axi_wr
  // One register read compared with an expected word
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      tmo(n);
    end while (!s_axi_rvalid);
    rsp = s_axi_rresp;
    check(s_axi_rdata, e);
    s_axi_rready <= 1'b0;
    // Let an edge pass so a following call never re-drives in this step
    @(posedge clk_i);
  endtask : rdchk
  // Walk the menu from normal display to the span step
  task automatic to_span();
    op_u.press(KEY_SEL, H3);
    repeat (3) op_u.press(KEY_SEL, 20);
  endtask : to_span
  // Cut a hang short
  initial begin
    repeat (100000) @(posedge clk_i);
    n_fail++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(relay_o, 1'b0);
    rdchk(OFS_SP_ON, SP_ON_DEF);
    rdchk(OFS_SP_OFF, SP_OFF_DEF);
    rdchk(OFS_ZERO, ZERO_DEF);
    rdchk(OFS_SPAN, SPAN_DEF);
    rdchk(OFS_STATUS, 32'h00000001);
    rdchk(8'h40, 32'h0);
    check(rsp, RESP_DECERR);
    axi_wr(OFS_SP_ON, 32'h5);
    check(rsp, RESP_SLVERR);
    $display("Test registers done");
    for (int i = 0; i < 6; i++) begin
      pressure_i <= pr[i];
      repeat (4) @(posedge clk_i);
      check(relay_o, rl[i]);
    end
    axi_wr(OFS_CFG, 32'h1);
    rdchk(OFS_CFG, 32'h1);
    check(relay_o, 1'b0);
    axi_wr(OFS_CFG, 32'h0);
    $display("Test relay done");
    op_u.press(KEY_SEL, H3);
    check(disp_code_o, DISP_VALUE);
    check(disp_val_o, SP_ON_DEF);
    repeat (2) op_u.press(KEY_UP, 20);
    check(disp_val_o, SP_ON_DEF + 2 * STEP);
    op_u.press(KEY_SEL, 20);
    check(disp_val_o, SP_OFF_DEF);
    op_u.press(KEY_SEL, 20);
    check(disp_code_o, DISP_ZERO);
    op_u.press(KEY_SEL, 20);
    check(disp_val_o, SPAN_DEF);
    op_u.press(KEY_DN, 20);
    check(disp_val_o, SPAN_DEF - STEP);
    op_u.press(KEY_SEL, 20);
    check(disp_code_o, DISP_PRESSURE);
    rdchk(OFS_SPAN, SPAN_DEF);
    rdchk(OFS_SP_ON, SP_ON_DEF + 2 * STEP);
    rdchk(OFS_ZERO, ZERO_DEF);
    pressure_i <= SP_OFF_DEF + STEP;
    repeat (4) @(posedge clk_i);
    pressure_i <= SP_ON_DEF + STEP;
    repeat (4) @(posedge clk_i);
    check(relay_o, 1'b1);
    $display("Test setpoints done");
    fork
      op_u.press(KEY_UP, 400);
      begin
        repeat (100) @(posedge clk_i);
        check(defaults_pending_indicator_o, 1'b1);
      end
    join
    check(disp_code_o, DISP_PRESSURE);
    rdchk(OFS_SP_ON, SP_ON_DEF + 2 * STEP);
    op_u.press(KEY_SEL, H3);
    repeat (2) op_u.press(KEY_SEL, 20);
    pressure_i <= 16'h0005;
    op_u.press(KEY_DN, 20);
    check(disp_code_o, DISP_PRESSURE);
    rdchk(OFS_ZERO, 32'h5);
    to_span();
    op_u.press(KEY_UP, 20);
    check(disp_val_o, SPAN_DEF + STEP);
    op_u.press(KEY_SEL, H3);
    check(disp_code_o, DISP_PRESSURE);
    rdchk(OFS_SPAN, SPAN_DEF + STEP);
    $display("Test zero and span done");
    op_u.press(KEY_UP, H5);
    check(disp_code_o, DISP_PRESSURE);
    rdchk(OFS_SP_ON, SP_ON_DEF);
    rdchk(OFS_ZERO, ZERO_DEF);
    rdchk(OFS_SPAN, SPAN_DEF);
    $display("Test defaults done");
    complete_run();
  end
endmodule : tb_top
